/* bench/psa_partner.sv */
// Purpose: Client and authentication server model for the admission bench
// Assumes: One identity request outstanding at a time
// Notes: Answer kind 0 silent, 1 accept, 2 reject, 3 server timeout
`timescale 1ns/1ps
module psa_partner (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [9:0] i_id_request,
    input wire logic [1:0] i_answer,
    input wire logic [3:0] i_delay,
    output logic o_verdict_valid,
    output psa_pkg::psa_verdict_s o_verdict
);
    logic [4:0] wait_ff;
    logic [3:0] port_ff;
    initial o_verdict_valid = 1'b0;
    always @(posedge i_sys_clk) begin
        o_verdict_valid <= 1'b0;
        // Idle verdict lines never hold the last value
        o_verdict <= ~o_verdict;
        if (!i_reset_n) begin
            wait_ff <= 5'h00;
            o_verdict <= '0;
        end else if (|i_id_request && i_answer != 2'h0) begin
            // Client replies with its identity; the server answers after the delay
            wait_ff <= {1'b0, i_delay} + 5'h01;
            for (int k = 0; k < 10; k++) begin
                if (i_id_request[k]) begin
                    port_ff <= 4'(k);
                end
            end
        end else if (wait_ff == 5'h01) begin
            wait_ff <= 5'h00;
            o_verdict_valid <= 1'b1;
            o_verdict <= '{port_ff, i_answer == 2'h1, i_answer == 2'h2, i_answer == 2'h3};
        end else if (wait_ff != 5'h00) begin
            wait_ff <= wait_ff - 5'h01;
        end
    end
endmodule // psa_partner

/* bench/tb_port_security_admission.sv */
// Purpose: Self-checking bench for the port security admission block
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Random ports, caps and answer delays from a fixed seed
`timescale 1ns/1ps
module tb_port_security_admission;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic lim_en, dx_en, fv, av, ev, e_eap, vv, f_v, f_p, f_l, f_s, e_p;
    logic [9:0][6:0] cap, cnt;
    logic [9:0][1:0] mode;
    logic [9:0] acmd, link, idr, authd, afail;
    logic [3:0] maxr, ap, ep, dly;
    logic [1:0] ans;
    psa_pkg::psa_frame_s fr;
    psa_pkg::psa_verdict_s vd;
    int miscompares = 0, tests_run = 0, cyc = 0, nreq = 0, p, n, k, base;

    always #5 sys_clk = ~sys_clk;

    psa_admission psa_admission_inst (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
        .i_limit_enable(lim_en), .i_source_address_learning_cap(cap), .i_dot1x_enable(dx_en),
        .i_port_mode(mode), .i_port_auto_authentication_cmd(acmd), .i_max_requests(maxr),
        .i_link_up(link), .i_frame_valid(fv), .i_frame(fr), .i_age_valid(av), .i_age_port(ap),
        .i_verdict_valid(vv), .i_verdict(vd), .i_egress_valid(ev), .i_egress_port(ep),
        .i_egress_is_eapol(e_eap), .o_fwd_valid(f_v), .o_fwd_pass(f_p), .o_fwd_learn(f_l),
        .o_fwd_to_server(f_s), .o_egress_pass(e_p), .o_id_request(idr), .o_authorized(authd),
        .o_auth_failed(afail), .o_learned_count(cnt));

    psa_partner psa_partner_inst (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
        .i_id_request(idr), .i_answer(ans), .i_delay(dly), .o_verdict_valid(vv),
        .o_verdict(vd));

    //**************************************************
    // Checks and drivers
    //**************************************************
    task automatic wrap_up();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk_cnt(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_cnt({6'h00, got}, {6'h00, exp});
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic send(input int pt, input logic eap, input logic [2:0] kd, input logic kn);
        tick(1);
        fr = '{4'(pt), eap, psa_pkg::psa_eap_e'(kd), kn};
        fv = 1'b1;
        @(posedge sys_clk);
        #1 fv = 1'b0;
    endtask
    task automatic egress(input logic eap);
        tick(1);
        {ep, e_eap, ev} = {4'(p), eap, 1'b1};
        @(posedge sys_clk);
        #1 ev = 1'b0;
    endtask
    task automatic age(input int pt);
        tick(1);
        ap = 4'(pt);
        av = 1'b1;
        @(posedge sys_clk);
        #1 av = 1'b0;
    endtask
    task automatic settle();
        for (int i = 0; i < 40 && authd[p] !== 1'b1 && afail[p] !== 1'b1; i++) tick(1);
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        nreq <= nreq + $countones(idr);
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    //**************************************************
    // Scenarios
    //**************************************************
    initial begin
        {lim_en, dx_en, fv, av, ev, e_eap, cap, mode, acmd, link, ap, ep, fr} = '0;
        {maxr, ans, dly} = {4'h2, 2'h0, 4'h3};
        n = $urandom(32'hdd23);
        repeat (3) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk_bit(|authd, 1'b0);
        lim_en = 1'b1;
        for (int t = 0; t < 4; t++) begin
            p = $urandom_range(7);
            n = (t == 0) ? 64 : $urandom_range(4, 1);
            cap[p] = 7'(n);
            for (k = 0; k < n; k++) begin
                send(p, 1'b0, 3'h0, 1'b0);
                chk_bit(f_l, 1'b1);
                chk_cnt(cnt[p], 7'(k + 1));
            end
            send(p, 1'b0, 3'h0, 1'b0);
            chk_bit(f_p, 1'b0);
            chk_bit(f_v, 1'b1);
            send(p, 1'b0, 3'h0, 1'b1);
            chk_bit(f_p, 1'b1);
            age(p);
            chk_cnt(cnt[p], 7'(n - 1));
            send(p, 1'b0, 3'h0, 1'b0);
            chk_bit(f_l, 1'b1);
            repeat (n) age(p);
            chk_cnt(cnt[p], 7'h00);
        end
        cap[8] = 7'h01;
        cap[p] = 7'h00;
        for (k = 0; k < 2; k++) begin
            send(8, 1'b0, 3'h0, 1'b0);
            chk_bit(f_p, 1'b1);
            send(p, 1'b0, 3'h0, 1'b0);
            chk_bit(f_p, 1'b1);
        end
        {lim_en, cap[p]} = {1'b0, 7'h01};
        repeat (2) send(p, 1'b0, 3'h0, 1'b0);
        chk_bit(f_p, 1'b1);
        dx_en = 1'b1;
        p = $urandom_range(9);
        {mode[p], acmd[p], base} = {psa_pkg::PSA_MODE_AUTO, 1'b1, nreq};
        link = 10'h3ff;
        tick(3);
        chk_cnt(7'(nreq - base), 7'h01);
        send(p, 1'b0, 3'h0, 1'b1);
        chk_bit(f_p, 1'b0);
        egress(1'b0);
        chk_bit(e_p, 1'b0);
        egress(1'b1);
        chk_bit(e_p, 1'b1);
        {ans, dly, base} = {2'h1, 4'($urandom_range(15)), nreq};
        send(p, 1'b1, 3'h1, 1'b1);
        chk_bit(f_s, 1'b1);
        settle();
        chk_bit(authd[p], 1'b1);
        chk_cnt(7'(nreq - base), 7'h01);
        send(p, 1'b0, 3'h0, 1'b1);
        chk_bit(f_p, 1'b1);
        send(p, 1'b1, 3'h2, 1'b1);
        chk_bit(authd[p], 1'b0);
        for (k = 2; k > 0; k--) begin
            ans = 2'(k);
            send(p, 1'b1, 3'h1, 1'b1);
            settle();
            chk_bit(authd[p], k == 1);
            chk_bit(afail[p], k == 2);
        end
        link[p] = 1'b0;
        tick(2);
        chk_bit(authd[p], 1'b0);
        {ans, base, link[p]} = {2'h3, nreq, 1'b1};
        tick(1);
        settle();
        chk_bit(afail[p], 1'b1);
        chk_cnt(7'(nreq - base), 7'h02);
        for (k = 0; k < 3; k++) begin
            mode[p] = 2'(k);
            send(p, 1'b0, 3'h0, 1'b1);
            chk_bit(f_p, k != 1);
        end
        {dx_en, base} = {1'b0, nreq};
        send(p, 1'b1, 3'h1, 1'b1);
        chk_bit(f_s | f_p, 1'b0);
        repeat (3) send(p, 1'b1, 3'h1, 1'b0);
        send(p, 1'b0, 3'h0, 1'b0);
        chk_bit(f_p, 1'b1);
        tick(3);
        chk_cnt(7'(nreq - base), 7'h00);
        wrap_up();
    end
endmodule // tb_port_security_admission

/* hdl/psa_admission.sv */
// Purpose: Per-port source-address learning cap and 802.1X authorization gate
// Assumes: Table lookup, aging and server relay framing are done outside
// Notes: One frame decision per clock, given in the cycle after the frame is offered
//
// What this block does
// - Per-port learned-address cap 1 to 64; zero disables the cap.
// - One global enable turns address limiting on or off.
// - Slots fill first come first served; stored entries never displaced.
// - Stored entries stay until aging removes them.
// - First unseen address on a port with a free slot is learned.
// - Full limited port forwards only known sources, blocks the rest.
// - Limiting applies only to fast ports zero through seven.
// - Every controlled port starts unauthorized.
// - Unauthorized port drops ingress and egress frames except EAPOL.
// - Auto mode sends identity request when link rises.
// - EAPOL start from client triggers an identity request.
// - With 802.1X disabled, EAPOL frames from clients are dropped.
// - Client EAP payload passed to server stripped of Ethernet header, unmodified.
// - Server EAP payload rewrapped in Ethernet toward the client.
// - Successful authentication authorizes the port for all traffic.
// - Failed authentication keeps port unauthorized, retry still allowed.
// - Server silence causes retransmit; fail after configured attempts.
// - Link down or EAPOL logoff returns port to unauthorized.
// - Four control modes: forced unauth, forced auth, auto, none.
`timescale 1ns/1ps
module psa_admission (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_limit_enable,
    input wire logic [9:0][6:0] i_source_address_learning_cap,
    input wire logic i_dot1x_enable,
    input wire logic [9:0][1:0] i_port_mode,
    input wire logic [9:0] i_port_auto_authentication_cmd,
    input wire logic [3:0] i_max_requests,
    input wire logic [9:0] i_link_up,
    input wire logic i_frame_valid,
    input wire psa_pkg::psa_frame_s i_frame,
    input wire logic i_age_valid,
    input wire logic [3:0] i_age_port,
    input wire logic i_verdict_valid,
    input wire psa_pkg::psa_verdict_s i_verdict,
    input wire logic i_egress_valid,
    input wire logic [3:0] i_egress_port,
    input wire logic i_egress_is_eapol,
    output logic o_fwd_valid,
    output logic o_fwd_pass,
    output logic o_fwd_learn,
    output logic o_fwd_to_server,
    output logic o_egress_pass,
    output logic [9:0] o_id_request,
    output logic [9:0] o_authorized,
    output logic [9:0] o_auth_failed,
    output logic [9:0][6:0] o_learned_count
);
    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic port_open(input psa_pkg::psa_mode_e m, input logic auth,
                                       input logic en);
        logic r;
        r = 1'b1;
        if (en) begin
            case (m)
                psa_pkg::PSA_MODE_FU: r = 1'b0;
                psa_pkg::PSA_MODE_FA: r = 1'b1;
                psa_pkg::PSA_MODE_AUTO: r = auth;
                default: r = 1'b1;
            endcase
        end
        return r;
    endfunction

    function automatic logic limited(input logic [3:0] p, input logic [6:0] cap,
                                     input logic en);
        return en && (p < 4'(psa_pkg::NUM_FAST)) && (cap != psa_pkg::LIMIT_OFF);
    endfunction

    // Caps above the largest legal value act as the largest value
    function automatic logic [6:0] cap_of(input logic [6:0] cap);
        return (cap > psa_pkg::LIMIT_MAX) ? psa_pkg::LIMIT_MAX : cap;
    endfunction

    // ********************************************************************
    // Per-port authorization state
    // ********************************************************************
    logic [9:0] auth_ff, nxt_auth;
    logic [9:0] fail_ff, nxt_fail;
    logic [9:0] link_ff;
    logic [9:0] idreq_ff, nxt_idreq;
    logic [9:0][3:0] tries_ff, nxt_tries;
    logic [9:0][6:0] cnt_ff, nxt_cnt;
    logic learn_now;

    always_comb begin
        nxt_auth = auth_ff;
        nxt_fail = fail_ff;
        nxt_idreq = '0;
        nxt_tries = tries_ff;
        for (int p = 0; p < psa_pkg::NUM_PORTS; p++) begin
            if (psa_pkg::psa_mode_e'(i_port_mode[p]) != psa_pkg::PSA_MODE_AUTO
                || !i_dot1x_enable) begin
                nxt_auth[p] = 1'b0;
                nxt_tries[p] = psa_pkg::RETRY_W0;
            end else begin
                if (i_link_up[p] && !link_ff[p] && i_port_auto_authentication_cmd[p]) begin
                    nxt_idreq[p] = 1'b1;
                    nxt_fail[p] = 1'b0;
                end
                if (i_frame_valid && i_frame.is_eapol && i_frame.port == 4'(p)
                    && i_frame.eap_kind == psa_pkg::PSA_EAP_START) begin
                    nxt_idreq[p] = 1'b1;
                    nxt_fail[p] = 1'b0;
                    nxt_tries[p] = psa_pkg::RETRY_W0;
                end
                if (i_verdict_valid && i_verdict.port == 4'(p)) begin
                    if (i_verdict.accept) begin
                        nxt_auth[p] = 1'b1;
                        nxt_tries[p] = psa_pkg::RETRY_W0;
                    end else if (i_verdict.reject) begin
                        nxt_auth[p] = 1'b0;
                        nxt_fail[p] = 1'b1;
                        nxt_tries[p] = psa_pkg::RETRY_W0;
                    end else if (i_verdict.timeout) begin
                        if (tries_ff[p] + 4'h1 >= i_max_requests) begin
                            nxt_fail[p] = 1'b1;
                            nxt_tries[p] = psa_pkg::RETRY_W0;
                        end else begin
                            nxt_idreq[p] = 1'b1;
                            nxt_tries[p] = tries_ff[p] + 4'h1;
                        end
                    end
                end
                if ((!i_link_up[p] && link_ff[p]) || (i_frame_valid && i_frame.is_eapol
                    && i_frame.port == 4'(p) && i_frame.eap_kind == psa_pkg::PSA_EAP_LOGOFF)) begin
                    nxt_auth[p] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            auth_ff <= '0;
            fail_ff <= '0;
            idreq_ff <= '0;
            tries_ff <= '0;
            link_ff <= '0;
        end else begin
            auth_ff <= nxt_auth;
            fail_ff <= nxt_fail;
            idreq_ff <= nxt_idreq;
            tries_ff <= nxt_tries;
            link_ff <= i_link_up;
        end
    end

    // ********************************************************************
    // Learned-address counters
    // ********************************************************************
    always_comb begin
        nxt_cnt = cnt_ff;
        for (int p = 0; p < psa_pkg::NUM_PORTS; p++) begin
            if (learn_now && i_frame.port == 4'(p)) begin
                nxt_cnt[p] = nxt_cnt[p] + 7'h01;
            end
            if (i_age_valid && i_age_port == 4'(p) && cnt_ff[p] != psa_pkg::CNT_ZERO) begin
                nxt_cnt[p] = nxt_cnt[p] - 7'h01;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // ********************************************************************
    // Ingress and egress decision
    // ********************************************************************
    logic [3:0] fp;
    logic open_in, lim, slot_free, eap_ok;
    logic nxt_fv, nxt_fp, nxt_fl, nxt_fs, nxt_ep;
    logic fv_ff, fp_ff, fl_ff, fs_ff, ep_ff;

    always_comb begin
        fp = i_frame.port;
        open_in = 1'b1;
        lim = 1'b0;
        slot_free = 1'b0;
        if (fp < 4'(psa_pkg::NUM_PORTS)) begin
            open_in = port_open(psa_pkg::psa_mode_e'(i_port_mode[fp]), auth_ff[fp],
                                i_dot1x_enable);
            lim = limited(fp, i_source_address_learning_cap[fp], i_limit_enable);
            slot_free = cnt_ff[fp] < cap_of(i_source_address_learning_cap[fp]);
        end
        eap_ok = i_frame.is_eapol && i_dot1x_enable;
        nxt_fv = i_frame_valid;
        nxt_fl = 1'b0;
        nxt_fs = 1'b0;
        nxt_fp = 1'b0;
        learn_now = 1'b0;
        if (i_frame_valid) begin
            if (i_frame.is_eapol) begin
                nxt_fp = 1'b0;
                nxt_fs = eap_ok;
            end else if (open_in) begin
                if (!lim || i_frame.sa_known) begin
                    nxt_fp = 1'b1;
                end else if (slot_free) begin
                    nxt_fp = 1'b1;
                    nxt_fl = 1'b1;
                    learn_now = 1'b1;
                end
            end
        end
        nxt_ep = 1'b0;
        if (i_egress_valid) begin
            if (i_egress_is_eapol) begin
                nxt_ep = i_dot1x_enable;
            end else if (i_egress_port < 4'(psa_pkg::NUM_PORTS)) begin
                nxt_ep = port_open(psa_pkg::psa_mode_e'(i_port_mode[i_egress_port]),
                                   auth_ff[i_egress_port], i_dot1x_enable);
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            fv_ff <= 1'b0;
            fp_ff <= 1'b0;
            fl_ff <= 1'b0;
            fs_ff <= 1'b0;
            ep_ff <= 1'b0;
        end else begin
            fv_ff <= nxt_fv;
            fp_ff <= nxt_fp;
            fl_ff <= nxt_fl;
            fs_ff <= nxt_fs;
            ep_ff <= nxt_ep;
        end
    end

    assign o_fwd_valid = fv_ff;
    assign o_fwd_pass = fp_ff;
    assign o_fwd_learn = fl_ff;
    assign o_fwd_to_server = fs_ff;
    assign o_egress_pass = ep_ff;
    assign o_id_request = idreq_ff;
    assign o_authorized = auth_ff;
    assign o_auth_failed = fail_ff;
    assign o_learned_count = cnt_ff;

    // ********************************************************************
    // Assertion helpers
    // ********************************************************************
    logic [9:0] auto_on, link_rise, link_fall, rise_req;

    always_comb begin
        auto_on = '0;
        for (int p = 0; p < psa_pkg::NUM_PORTS; p++) begin
            auto_on[p] = i_dot1x_enable
                && (psa_pkg::psa_mode_e'(i_port_mode[p]) == psa_pkg::PSA_MODE_AUTO);
        end
    end

    assign link_rise = i_link_up & ~link_ff;
    assign link_fall = link_ff & ~i_link_up;
    assign rise_req = link_rise & i_port_auto_authentication_cmd & auto_on;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    a_start_idreq: assert property (i_frame_valid && i_frame.is_eapol && i_dot1x_enable
        && i_frame.eap_kind == psa_pkg::PSA_EAP_START && i_frame.port < 4'h a
        && i_port_mode[i_frame.port] == 2'h3 |=> o_id_request[$past(i_frame.port)])
        else $error("start frame gave no identity request");
    a_eapol_off_drop: assert property (i_frame_valid && i_frame.is_eapol && !i_dot1x_enable
        |=> !o_fwd_to_server && !o_fwd_pass)
        else $error("EAPOL passed with 802.1X disabled");
    a_unauth_block: assert property (i_frame_valid && !i_frame.is_eapol && i_dot1x_enable
        && i_frame.port < 4'h a && i_port_mode[i_frame.port] == 2'h1 |=> !o_fwd_pass)
        else $error("forced unauthorized port passed traffic");
    a_full_block: assert property (i_frame_valid && !i_frame.is_eapol && !i_frame.sa_known
        && i_limit_enable && i_frame.port < 4'h8 && i_source_address_learning_cap[i_frame.port]
        != 7'h00 && o_learned_count[i_frame.port] >= i_source_address_learning_cap[i_frame.port]
        |=> !o_fwd_pass && !o_fwd_learn)
        else $error("unknown source passed on full port");
    a_learn_count: assert property (o_fwd_learn |-> o_learned_count[$past(i_frame.port)]
        == $past(o_learned_count[i_frame.port]) + 7'h01 || $past(i_age_valid))
        else $error("learned count did not rise");
    a_accept_auth: assert property (i_verdict_valid && i_verdict.accept && i_dot1x_enable
        && i_verdict.port < 4'h a && i_port_mode[i_verdict.port] == 2'h3 && i_link_up[i_verdict.port]
        && $past(i_link_up[i_verdict.port]) && !i_frame_valid
        |=> o_authorized[$past(i_verdict.port)])
        else $error("accept did not authorize");
    a_linkdown_unauth: assert property (link_fall != 10'h000
        |=> (o_authorized & $past(link_fall)) == 10'h000)
        else $error("link down left port authorized");
    a_linkup_idreq: assert property (rise_req != 10'h000
        |=> (o_id_request & $past(rise_req)) == $past(rise_req))
        else $error("link rise gave no identity request");
    a_nonauto_clear: assert property ((o_authorized & ~$past(auto_on)) == 10'h000)
        else $error("port authorized outside automatic mode");
    a_fail_limit: assert property (i_verdict_valid && i_verdict.timeout && !i_verdict.accept
        && !i_verdict.reject && i_verdict.port < 4'ha && auto_on[i_verdict.port]
        && tries_ff[i_verdict.port] + 4'h1 >= i_max_requests |=> o_auth_failed[$past(i_verdict.port)])
        else $error("unanswered requests did not end in failure");
    a_egress_block: assert property (i_egress_valid && !i_egress_is_eapol && i_egress_port < 4'ha
        && auto_on[i_egress_port] && !o_authorized[i_egress_port] |=> !o_egress_pass)
        else $error("egress passed on unauthorized port");
    a_forced_open: assert property (i_frame_valid && !i_frame.is_eapol && i_dot1x_enable
        && !i_limit_enable && i_frame.port < 4'ha && i_port_mode[i_frame.port] == 2'h2
        |=> o_fwd_pass)
        else $error("forced authorized port dropped traffic");
    a_logoff_unauth: assert property (i_frame_valid && i_frame.is_eapol
        && i_frame.eap_kind == psa_pkg::PSA_EAP_LOGOFF && i_frame.port < 4'ha
        |=> !o_authorized[$past(i_frame.port)])
        else $error("logoff left port authorized");
    a_fwd_follow: assert property (i_frame_valid |=> o_fwd_valid)
        else $error("frame got no decision");
    a_eapol_no_pass: assert property (i_frame_valid && i_frame.is_eapol |=> !o_fwd_pass)
        else $error("EAPOL frame forwarded as data");
    a_gig_unlimited: assert property (i_frame_valid && !i_frame.is_eapol && i_frame.port >= 4'h8
        && i_frame.port < 4'h a && !i_dot1x_enable |=> o_fwd_pass && !o_fwd_learn)
        else $error("gigabit port was limited");
    a_reset_unauth: assert property ($rose(i_reset_n) |-> o_authorized == 10'h000)
        else $error("port authorized out of reset");

    c_learn: cover property (o_fwd_learn);
    c_auth: cover property (|o_authorized);
    c_fail: cover property (|o_auth_failed);
    c_idreq: cover property (|o_id_request);
    c_block: cover property (o_fwd_valid && !o_fwd_pass);
endmodule // psa_admission

/* hdl/psa_pkg.sv */
// Purpose: Shared constants and types for the port security admission block
// Assumes: Eight limited fast ports, two gigabit ports
// Notes: Frame classification is done upstream; this block sees one descriptor per frame
package psa_pkg;
    localparam int NUM_PORTS = 10;
    localparam int NUM_FAST = 8;
    localparam int PORT_W = 4;
    localparam int CNT_W = 7;
    localparam logic [6:0] LIMIT_MAX = 7'h40;
    localparam logic [6:0] LIMIT_OFF = 7'h00;
    localparam logic [3:0] RETRY_W0 = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;

    typedef enum logic [1:0] {
        PSA_MODE_NONE,
        PSA_MODE_FU,
        PSA_MODE_FA,
        PSA_MODE_AUTO
    } psa_mode_e;

    typedef enum logic [2:0] {
        PSA_EAP_NONE,
        PSA_EAP_START,
        PSA_EAP_LOGOFF,
        PSA_EAP_OTHER
    } psa_eap_e;

    // Ingress frame descriptor from the parser
    typedef struct packed {
        logic [3:0] port;
        logic is_eapol;
        psa_eap_e eap_kind;
        logic sa_known;
    } psa_frame_s;

    // Server verdict for one port
    typedef struct packed {
        logic [3:0] port;
        logic accept;
        logic reject;
        logic timeout;
    } psa_verdict_s;
endpackage
